// ### hw/adc_seq_defines.svh
// Offsets, field positions and timing counts of the conversion sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define ADDR_CONFIG    8'h00
`define ADDR_COMMAND   8'h04
`define ADDR_FIFO      8'h08
`define ADDR_SINGLE    8'h0C
`define ADDR_STATUS    8'h10
`define ADDR_INT_STS   8'h14
`define ADDR_INT_CLR   8'h18
`define ADDR_INT_EN    8'h1C
`define CFG_RESET      17'h00000
`define CMD_SELECT_BIT 0
`define CMD_CONV_BIT   4
`define EV_DONE        0
`define EV_THRESH      1
`define EV_IGNORED     2
`define FIFO_DEPTH     8
`define CONV_SCLK_EDGES 5'h0E
`endif

// ### hw/adc_seq_pkg.sv
// Types shared by the conversion sequencer
package adc_seq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_REPEAT = 2'h1,
    MODE_SWEEP  = 2'h2,
    MODE_RSWEEP = 2'h3
  } mode_e;
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_e;
  typedef logic [2:0] chan_t;
  typedef logic [9:0] result_t;
endpackage

// ### hw/adc_conversion_mode_sequencer.sv
// Conversion-mode sequencer with result FIFO, APB registers and interrupt
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "adc_seq_defines.svh"

module adc_conversion_mode_sequencer (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Link pins
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   conversion_start_pin_n,
  // Converter core
  input  wire adc_seq_pkg::result_t   adc_result,
  output adc_seq_pkg::chan_t          mux_channel,
  output logic                        sampling,
  // Status outputs
  output logic                        eoc,
  output logic                        irq
);
  import adc_seq_pkg::*;

  logic [2:0]  sclk_sy;
  logic [2:0]  cs_sy;
  logic [2:0]  cst_sy;
  logic [16:0] config_register;
  logic [16:0] next_cfg;
  mode_e       mode;
  logic [3:0]  thr_cnt;
  conv_state_e st;
  conv_state_e next_st;
  logic [4:0]  edges;
  logic [4:0]  next_edges;
  chan_t       sel_ch;
  chan_t       next_sel_ch;
  logic        chan_sel;
  logic        next_chan_sel;
  chan_t       conv_ch;
  chan_t       next_conv_ch;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic        thr_hit;
  logic        next_thr_hit;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [2:0]  rp;
  logic [2:0]  next_rp;
  logic [2:0]  wp;
  logic [2:0]  next_wp;
  result_t     single_res;
  result_t     next_single_res;
  logic [2:0]  int_sts;
  logic [2:0]  next_int_sts;
  logic [2:0]  int_en;
  logic [2:0]  next_int_en;
  logic [12:0] mem [`FIFO_DEPTH];
  logic        push;
  logic        pop;
  logic        flush;
  logic        wr;
  logic        rd;
  logic        cfg_wr;
  logic        trig;
  logic        sclk_rise;
  logic        done_now;
  logic        start_ok;
  logic [2:0]  ev;

  // Pick the sweep entry at a position
  function automatic chan_t order_at(input logic [16:0] c, input logic [1:0] i);
    order_at = c[5+3*i +: 3];
  endfunction

  // Pin synchronisers plus one stage for edge finding
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_sy <= 3'h0;
      cs_sy   <= 3'h7;
      cst_sy  <= 3'h7;
    end else begin
      sclk_sy <= {sclk_sy[1:0], sclk};
      cs_sy   <= {cs_sy[1:0], cs_n};
      cst_sy  <= {cst_sy[1:0], conversion_start_pin_n};
    end
  end

  // Decoded strobes
  assign mode      = mode_e'(config_register[1:0]);
  assign thr_cnt   = {1'b0, config_register[4:2]} + 4'h1;
  assign wr        = psel && penable && pwrite;
  assign rd        = psel && penable && !pwrite;
  assign cfg_wr    = wr && (paddr == `ADDR_CONFIG);
  assign sclk_rise = sclk_sy[1] && !sclk_sy[2];
  assign trig      = (wr && paddr == `ADDR_COMMAND && pwdata[`CMD_CONV_BIT])
                     || (cs_sy[2] && !cs_sy[1]) || (cst_sy[2] && !cst_sy[1]);
  assign done_now  = (st == ST_CONV) && sclk_rise && (edges == `CONV_SCLK_EDGES - 5'h01);
  assign pop       = rd && (paddr == `ADDR_FIFO) && (cnt != 4'h0) && !cfg_wr;

  // Acceptance of a conversion trigger per mode
  always_comb begin
    unique case (mode)
      MODE_SINGLE: start_ok = chan_sel;
      MODE_REPEAT: start_ok = chan_sel && !thr_hit;
      MODE_SWEEP:  start_ok = !thr_hit;
      MODE_RSWEEP: start_ok = 1'b1;
    endcase
  end

  // Sequencer next state
  always_comb begin
    next_cfg        = config_register;
    next_st         = st;
    next_edges      = edges;
    next_sel_ch     = sel_ch;
    next_chan_sel   = chan_sel;
    next_conv_ch    = conv_ch;
    next_idx        = idx;
    next_thr_hit    = thr_hit;
    next_single_res = single_res;
    next_int_en     = int_en;
    push            = 1'b0;
    flush           = 1'b0;
    ev              = 3'h0;
    if (cfg_wr) begin
      next_cfg      = pwdata[16:0];
      flush         = 1'b1;
      next_thr_hit  = 1'b0;
      next_idx      = 2'h0;
      next_chan_sel = 1'b0;
      next_st       = ST_IDLE;
    end else begin
      if (wr && paddr == `ADDR_COMMAND && pwdata[`CMD_SELECT_BIT]) begin
        next_chan_sel = 1'b1;
        next_sel_ch   = pwdata[3:1];
      end
      if (wr && paddr == `ADDR_INT_EN) begin
        next_int_en = pwdata[2:0];
      end
      if (trig && st == ST_IDLE) begin
        if (start_ok) begin
          next_st    = ST_CONV;
          next_edges = 5'h00;
          if (mode == MODE_RSWEEP && thr_hit) begin
            flush        = 1'b1;
            next_thr_hit = 1'b0;
            next_idx     = 2'h0;
            next_conv_ch = order_at(config_register, 2'h0);
          end else if (mode[1]) begin
            next_conv_ch = order_at(config_register, idx);
          end else begin
            next_conv_ch = sel_ch;
          end
        end else begin
          ev[`EV_IGNORED] = 1'b1;
        end
      end
      if (st == ST_CONV && sclk_rise) begin
        next_edges = edges + 5'h01;
      end
      if (done_now) begin
        next_st         = ST_IDLE;
        ev[`EV_DONE]    = 1'b1;
        if (mode == MODE_SINGLE) begin
          next_single_res = adc_result;
        end else begin
          push     = 1'b1;
          next_idx = idx + 2'h1;
          if (cnt - {3'h0, pop} + 4'h1 >= thr_cnt) begin
            next_thr_hit     = 1'b1;
            ev[`EV_THRESH]   = 1'b1;
          end
        end
      end
      if (pop && cnt == 4'h1 && !push && thr_hit) begin
        next_thr_hit = 1'b0;
        next_idx     = 2'h0;
        if (mode == MODE_REPEAT) begin
          next_chan_sel = 1'b0;
        end
      end
    end
  end

  // FIFO pointers and count
  always_comb begin
    if (flush) begin
      next_rp  = 3'h0;
      next_wp  = {2'h0, push};
      next_cnt = {3'h0, push};
    end else begin
      next_rp  = rp + {2'h0, pop};
      next_wp  = wp + {2'h0, push};
      next_cnt = cnt + {3'h0, push} - {3'h0, pop};
    end
  end

  // Sticky events: set wins over clear
  always_comb begin
    next_int_sts = int_sts | ev;
    if (wr && paddr == `ADDR_INT_CLR) begin
      next_int_sts = (int_sts & ~pwdata[2:0]) | ev;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      config_register <= `CFG_RESET;
      st              <= ST_IDLE;
      edges           <= 5'h00;
      sel_ch          <= 3'h0;
      chan_sel        <= 1'b0;
      conv_ch         <= 3'h0;
      idx             <= 2'h0;
      thr_hit         <= 1'b0;
      cnt             <= 4'h0;
      rp              <= 3'h0;
      wp              <= 3'h0;
      single_res      <= 10'h000;
      int_sts         <= 3'h0;
      int_en          <= 3'h0;
    end else begin
      config_register <= next_cfg;
      st              <= next_st;
      edges           <= next_edges;
      sel_ch          <= next_sel_ch;
      chan_sel        <= next_chan_sel;
      conv_ch         <= next_conv_ch;
      idx             <= next_idx;
      thr_hit         <= next_thr_hit;
      cnt             <= next_cnt;
      rp              <= next_rp;
      wp              <= next_wp;
      single_res      <= next_single_res;
      int_sts         <= next_int_sts;
      int_en          <= next_int_en;
    end
  end

  // Result storage, tagged with channel
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[flush ? 3'h0 : wp] <= {conv_ch, adc_result};
    end
  end

  // Register read mux and bus answer
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      `ADDR_CONFIG:  prdata = {15'h0, config_register};
      `ADDR_FIFO:    prdata = (cnt != 4'h0) ? {1'b1, 15'h0, 3'h0, mem[rp]} : 32'h00000000;
      `ADDR_SINGLE:  prdata = {22'h0, single_res};
      `ADDR_STATUS:  prdata = {20'h00000, sel_ch, idx, chan_sel, st == ST_CONV, thr_hit, cnt};
      `ADDR_INT_STS: prdata = {29'h0, int_sts};
      `ADDR_INT_EN:  prdata = {29'h0, int_en};
      `ADDR_COMMAND, `ADDR_INT_CLR: prdata = 32'h00000000;
      default:       pslverr = psel && penable;
    endcase
  end

  // Outputs
  assign pready      = 1'b1;
  assign mux_channel = conv_ch;
  assign sampling    = (st == ST_CONV);
  assign eoc         = thr_hit;
  assign irq         = |(int_sts & int_en);

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_idle_trig;
    st == ST_IDLE && trig && !cfg_wr;
  endsequence

  property p_sweep_stop;
    s_idle_trig ##0 (mode == MODE_SWEEP && thr_hit) |=> st == ST_IDLE;
  endproperty
  a_sweep_stop: assert property (p_sweep_stop) else $error("sweep ran past threshold");

  property p_sweep_ignore;
    s_idle_trig ##0 (mode == MODE_SWEEP && thr_hit) |=>
      int_sts[`EV_IGNORED] && cnt == $past(cnt) - {3'h0, $past(pop)};
  endproperty
  a_sweep_ignore: assert property (p_sweep_ignore) else $error("conversion not ignored");

  property p_rsweep_restart;
    s_idle_trig ##0 (mode == MODE_RSWEEP && thr_hit) |=>
      cnt == 4'h0 && st == ST_CONV && conv_ch == order_at(config_register, 2'h0);
  endproperty
  a_rsweep_restart: assert property (p_rsweep_restart) else $error("sweep not restarted");

  property p_need_select;
    s_idle_trig ##0 (!mode[1] && !chan_sel) |=> st == ST_IDLE;
  endproperty
  a_need_select: assert property (p_need_select) else $error("conversion without select");

  property p_single_bypass;
    done_now && mode == MODE_SINGLE && !cfg_wr |=>
      cnt == $past(cnt) - {3'h0, $past(pop)} && single_res == $past(adc_result);
  endproperty
  a_single_bypass: assert property (p_single_bypass) else $error("single result misplaced");

  property p_drain_reselect;
    pop && cnt == 4'h1 && !push && thr_hit && mode == MODE_REPEAT && !cfg_wr |=>
      !chan_sel && !thr_hit;
  endproperty
  a_drain_reselect: assert property (p_drain_reselect) else $error("select not cleared");

  property p_sweep_order;
    done_now && mode[1] && !flush |=> mem[$past(wp)] == {$past(conv_ch), $past(adc_result)};
  endproperty
  a_sweep_order: assert property (p_sweep_order) else $error("FIFO order broken");

  property p_thresh_flag;
    !thr_hit && next_thr_hit |=> eoc && int_sts[`EV_THRESH] && (irq || !int_en[`EV_THRESH]);
  endproperty
  a_thresh_flag: assert property (p_thresh_flag) else $error("threshold not flagged");

endmodule // adc_conversion_mode_sequencer

// ### verif/adc_host_pins.sv
// Host-side pin model: link clock, trigger pins, converter result
`timescale 1ns/100ps
module adc_host_pins (
  // Clock and converter state
  input  wire logic                 clk_sys,
  input  wire logic                 sampling,
  input  wire adc_seq_pkg::chan_t   mux_channel,
  input  wire logic [6:0]           base,
  // Driven pins
  output logic                      sclk,
  output logic                      cs_n,
  output logic                      conversion_start_pin_n,
  output adc_seq_pkg::result_t      adc_result
);
  import adc_seq_pkg::*;
  // Link clock runs only during a conversion
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    conversion_start_pin_n = 1'b1;
    #37;
    forever begin
      #100;
      sclk = (sampling === 1'b1) ? ~sclk : 1'b0;
    end
  end
  // Result is garbage outside a conversion
  assign adc_result = sampling ? {base, mux_channel} : ~{base, mux_channel};
  task automatic trigger(input logic use_cs);
    begin
      if (use_cs) cs_n <= 1'b0;
      else conversion_start_pin_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      cs_n <= 1'b1;
      conversion_start_pin_n <= 1'b1;
      @(posedge clk_sys);
    end
  endtask
endmodule // adc_host_pins

// ### verif/adc_conversion_mode_sequencer_tb_top.sv
// Self-checking bench for the conversion-mode sequencer
`timescale 1ns/100ps
`include "adc_seq_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module adc_conversion_mode_sequencer_tb_top;
  import adc_seq_pkg::*;
  logic          clk_sys = 1'b0;
  logic          arst_n = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready, pslverr, sclk, cs_n, start_n, sampling, eoc, irq;
  chan_t         mux_channel;
  result_t       adc_result;
  logic [6:0]    base;
  logic [32:0]   exp_q[$];
  logic [32:0]   e;
  int            seed = 57957;
  int            err_count = 0;
  int            n_compared = 0;
  int            cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  adc_conversion_mode_sequencer u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .cs_n(cs_n), .conversion_start_pin_n(start_n),
    .adc_result(adc_result), .mux_channel(mux_channel), .sampling(sampling),
    .eoc(eoc), .irq(irq));
  adc_host_pins u_host (.clk_sys(clk_sys), .sampling(sampling),
    .mux_channel(mux_channel), .base(base), .sclk(sclk), .cs_n(cs_n),
    .conversion_start_pin_n(start_n), .adc_result(adc_result));
  function automatic logic [31:0] cfg(input logic [1:0] mode);
    return {15'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, mode};
  endfunction
  function automatic logic [31:0] fifo_word(input chan_t ch);
    return {1'b1, 18'h0, ch, base, ch};
  endfunction
  task automatic report_and_stop();
    begin
      $display("Errors %0d, comparisons %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    exp_q.push_back({1'b0, d});
    apb(1'b0, a, 32'h0);
  endtask
  // Trigger by command, chip select or start pin; wait for the end
  task automatic conv(input int how);
    begin
      if (how == 0) apb(1'b1, `ADDR_COMMAND, 32'h10);
      else u_host.trigger(how == 1);
      // Only the run timeout ends a stuck conversion
      while (sampling !== 1'b1) @(posedge clk_sys);
      while (sampling !== 1'b0) @(posedge clk_sys);
      idle(2);
    end
  endtask
  // Read-data watcher and run timeout
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) `CHK(pslverr, 1'b1)
      else `CHK({pslverr, prdata}, e)
    end
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    base = 7'($random(seed));
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`ADDR_CONFIG, 32'h0);
    rd(`ADDR_STATUS, 32'h0);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h20, 32'h0);
    apb(1'b1, `ADDR_CONFIG, cfg(2'h1));
    apb(1'b1, `ADDR_INT_EN, 32'h2);
    rd(`ADDR_INT_EN, 32'h2);
    apb(1'b1, `ADDR_COMMAND, 32'h10);
    idle(4);
    rd(`ADDR_INT_STS, 32'h4);
    apb(1'b1, `ADDR_INT_CLR, 32'h7);
    apb(1'b1, `ADDR_COMMAND, 32'hB);
    for (int i = 0; i < 4; i++) conv(i % 3);
    `CHK(eoc, 1'b1);
    `CHK(irq, 1'b1);
    for (int i = 0; i < 4; i++) rd(`ADDR_FIFO, fifo_word(3'h5));
    `CHK(eoc, 1'b0);
    apb(1'b1, `ADDR_INT_CLR, 32'h7);
    apb(1'b1, `ADDR_COMMAND, 32'h10);
    idle(4);
    rd(`ADDR_INT_STS, 32'h4);
    `CHK(irq, 1'b0);
    rd(`ADDR_FIFO, 32'h0);
    apb(1'b1, `ADDR_CONFIG, cfg(2'h0));
    apb(1'b1, `ADDR_COMMAND, 32'h5);
    conv(2);
    rd(`ADDR_SINGLE, {22'h0, base, 3'h2});
    rd(`ADDR_STATUS, 32'h440);
    base = 7'($random(seed));
    apb(1'b1, `ADDR_CONFIG, cfg(2'h2));
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) conv(i % 3);
      `CHK(eoc, 1'b1);
      apb(1'b1, `ADDR_INT_CLR, 32'h7);
      apb(1'b1, `ADDR_COMMAND, 32'h10);
      idle(2);
      `CHK(sampling, 1'b0);
      rd(`ADDR_INT_STS, 32'h4);
      for (int i = 0; i < 4; i++) rd(`ADDR_FIFO, fifo_word(3'(i + 1)));
    end
    rd(`ADDR_FIFO, 32'h0);
    apb(1'b1, `ADDR_CONFIG, cfg(2'h3));
    for (int i = 0; i < 5; i++) conv(i % 3);
    `CHK(eoc, 1'b0);
    rd(`ADDR_FIFO, fifo_word(3'h1));
    rd(`ADDR_FIFO, 32'h0);
    conv(1);
    conv(2);
    apb(1'b1, `ADDR_CONFIG, cfg(2'h3));
    rd(`ADDR_FIFO, 32'h0);
    idle(2);
    report_and_stop();
  end
endmodule // adc_conversion_mode_sequencer_tb_top
